// *** hdl/dur_map.svh ***
// Register map, reset values and field positions of the dual channel block.
// Assumes inclusion by bare name from the design module and the bench.
`ifndef DUR_MAP_SVH
`define DUR_MAP_SVH
`define DUR_OFS_INT_EN      12'h000
`define DUR_OFS_FIFO_CTL    12'h004
`define DUR_OFS_INT_STAT    12'h008
`define DUR_OFS_LINE_CTL    12'h00C
`define DUR_OFS_MODEM_CTL   12'h010
`define DUR_OFS_LINE_STAT   12'h014
`define DUR_OFS_MODEM_STAT  12'h018
`define DUR_OFS_SCRATCH     12'h01C
`define DUR_OFS_ENH_FEAT    12'h020
`define DUR_OFS_RESUME1     12'h024
`define DUR_OFS_RESUME2     12'h028
`define DUR_OFS_PAUSE1      12'h02C
`define DUR_OFS_PAUSE2      12'h030
`define DUR_OFS_DIV_LO      12'h034
`define DUR_OFS_DIV_HI      12'h038
`define DUR_OFS_EVT_STAT    12'h03C
`define DUR_OFS_EVT_CLR     12'h040
`define DUR_OFS_EVT_EN      12'h044
`define DUR_OFS_PWR_CTL     12'h048
`define DUR_CH_BIT          8
`define DUR_RST_ZERO        8'h00
`define DUR_RST_INT_STAT    8'h01
`define DUR_RST_LINE_STAT   8'h60
`define DUR_RST_SCRATCH     8'hFF
`define DUR_MCR_DTR         0
`define DUR_MCR_RTS         1
`define DUR_MCR_OP2         3
`define DUR_EVT_W           4
`define DUR_EVT_WRITE       0
`define DUR_EVT_MODEM       1
`endif

// *** hdl/dur_pkg.sv ***
// Types shared by the dual channel reset-state block.
// Assumes the map header sits beside it.
package dur_pkg;
	typedef struct packed {
		logic [7:0] int_en;
		logic [7:0] fifo_ctl;
		logic [7:0] line_ctl;
		logic [7:0] modem_ctl;
		logic [7:0] scratch;
		logic [7:0] enh_feat;
		logic [7:0] resume1;
		logic [7:0] resume2;
		logic [7:0] pause1;
		logic [7:0] pause2;
	} dur_chan_regs_t;

	typedef struct packed {
		logic tx;
		logic user_output_two_n;
		logic rts_n;
		logic dtr_n;
		logic rx_ready_n;
		logic tx_ready_n;
	} dur_chan_pins_t;

	typedef enum logic [1:0] {
		DUR_HOLD = 2'b00,
		DUR_LIVE = 2'b01
	} dur_phase_t;
endpackage

// *** hdl/dur_top.sv ***
// Two UART channels: reset state, character registers and APB access.
// Assumes a synchronous APB master on pclk; modem inputs synchronous.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`include "dur_map.svh"
module dur_top
	import dur_pkg::*;
(
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Modem inputs, active low, one bit per channel
	input  wire logic [1:0]  cts_n,
	input  wire logic [1:0]  dsr_n,
	input  wire logic [1:0]  ri_n,
	input  wire logic [1:0]  cd_n,
	// Serial and modem outputs per channel
	output dur_chan_pins_t [1:0] pins,
	// Interrupt pin as level and enable
	output logic             irq,
	output logic             irq_oe,
	// Sleep input; power-save is set through the power control register
	input  wire logic        sleep_mode
);
	dur_chan_regs_t [1:0] regs;
	logic [1:0][7:0]      div_lo;
	logic [1:0][7:0]      div_hi;
	logic [1:0][3:0]      modem_in;
	logic [1:0][3:0]      modem_delta;
	logic [1:0][`DUR_EVT_W-1:0] evt_stat;
	logic [1:0][`DUR_EVT_W-1:0] evt_en;
	logic                 power_save;
	dur_phase_t           phase;
	logic                 wr_en;
	logic                 rd_en;
	logic                 ch;
	logic [11:0]          ofs;
	logic                 hit;
	logic [31:0]          next_rdata;
	logic [1:0][3:0]      live_modem;
	logic                 modem_primed;
	logic [1:0][3:0]      pin_modem;
	logic [1:0][3:0]      modem_change;
	logic [1:0][`DUR_EVT_W-1:0] evt_set;

	function automatic logic [11:0] reg_ofs(input logic [11:0] a);
		reg_ofs = {a[11:`DUR_CH_BIT+1], 1'b0, a[`DUR_CH_BIT-1:0]};
	endfunction

	function automatic logic [7:0] modem_stat(input logic [3:0] lvl,
		input logic [3:0] dlt);
		modem_stat = {~lvl, dlt};
	endfunction

	// Power-save blocks the write strobe only; reads still pass
	assign wr_en  = psel && penable && pwrite && !power_save;
	assign rd_en  = psel && penable && !pwrite;
	assign ch     = paddr[`DUR_CH_BIT];
	assign ofs    = reg_ofs(paddr);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;

	// No change is flagged until the first sample after reset is taken,
	// so a pin that is already active at release reads as a level only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			modem_primed <= 1'b0;
		else
			modem_primed <= 1'b1;
	end

	// Modem inputs frozen while isolated
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			modem_in    <= '0;
			modem_delta <= '0;
		end
		else
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (!power_save)
					modem_in[c] <= pin_modem[c];
				// A change in the clearing cycle survives the clear
				if (rd_en && ch == c[0] && ofs == `DUR_OFS_MODEM_STAT)
					modem_delta[c] <= modem_change[c];
				else
					modem_delta[c] <= modem_delta[c] | modem_change[c];
			end
		end
	end

	// Upper status bits follow live pins through reset
	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			pin_modem[c] = {cd_n[c], ri_n[c], dsr_n[c], cts_n[c]};
			modem_change[c] = (modem_primed && !power_save) ?
				(modem_in[c] ^ pin_modem[c]) : '0;
			live_modem[c] = power_save ? modem_in[c]
				: pin_modem[c];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase <= DUR_HOLD;
		else if (wr_en)
			phase <= DUR_LIVE;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			power_save <= 1'b0;
		else if (psel && penable && pwrite && ofs == `DUR_OFS_PWR_CTL)
			power_save <= pwdata[0];
	end

	// Per-channel control registers, each channel its own copy
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int c = 0; c < 2; c++)
			begin
				regs[c].int_en    <= `DUR_RST_ZERO;
				regs[c].fifo_ctl  <= `DUR_RST_ZERO;
				regs[c].line_ctl  <= `DUR_RST_ZERO;
				regs[c].modem_ctl <= `DUR_RST_ZERO;
				regs[c].scratch   <= `DUR_RST_SCRATCH;
				regs[c].enh_feat  <= `DUR_RST_ZERO;
				regs[c].resume1   <= `DUR_RST_ZERO;
				regs[c].resume2   <= `DUR_RST_ZERO;
				regs[c].pause1    <= `DUR_RST_ZERO;
				regs[c].pause2    <= `DUR_RST_ZERO;
			end
		end
		else if (wr_en)
		begin
			// Sleep does not touch scratch; only reset restores it
			unique case (ofs)
			`DUR_OFS_INT_EN:    regs[ch].int_en    <= pwdata[7:0];
			`DUR_OFS_FIFO_CTL:  regs[ch].fifo_ctl  <= pwdata[7:0];
			`DUR_OFS_LINE_CTL:  regs[ch].line_ctl  <= pwdata[7:0];
			`DUR_OFS_MODEM_CTL: regs[ch].modem_ctl <= pwdata[7:0];
			`DUR_OFS_SCRATCH:   regs[ch].scratch   <= pwdata[7:0];
			`DUR_OFS_ENH_FEAT:  regs[ch].enh_feat  <= pwdata[7:0];
			`DUR_OFS_RESUME1:   regs[ch].resume1   <= pwdata[7:0];
			`DUR_OFS_RESUME2:   regs[ch].resume2   <= pwdata[7:0];
			`DUR_OFS_PAUSE1:    regs[ch].pause1    <= pwdata[7:0];
			`DUR_OFS_PAUSE2:    regs[ch].pause2    <= pwdata[7:0];
			default:            regs[ch].scratch   <= regs[ch].scratch;
			endcase
		end
	end

	// Divisors have no reset value by design
	always_ff @(posedge pclk)
	begin
		if (wr_en && ofs == `DUR_OFS_DIV_LO)
			div_lo[ch] <= pwdata[7:0];
		if (wr_en && ofs == `DUR_OFS_DIV_HI)
			div_hi[ch] <= pwdata[7:0];
	end

	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			evt_set[c] = '0;
			evt_set[c][`DUR_EVT_WRITE] = wr_en && ch == c[0];
			evt_set[c][`DUR_EVT_MODEM] = |modem_delta[c];
		end
	end

	// Events: set wins over a simultaneous clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			evt_stat <= '0;
			evt_en   <= '0;
		end
		else
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (wr_en && ch == c[0] && ofs == `DUR_OFS_EVT_CLR)
					evt_stat[c] <= (evt_stat[c] & ~pwdata[`DUR_EVT_W-1:0])
						| evt_set[c];
				else
					evt_stat[c] <= evt_stat[c] | evt_set[c];
				if (wr_en && ch == c[0] && ofs == `DUR_OFS_EVT_EN)
					evt_en[c] <= pwdata[`DUR_EVT_W-1:0];
			end
		end
	end

	// Driven only after the first write, tri-stated in reset
	assign irq    = |(evt_stat[0] & evt_en[0]) | |(evt_stat[1] & evt_en[1]);
	assign irq_oe = (phase == DUR_LIVE) && !power_save;

	// Pins: all idle high except transmit ready
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int c = 0; c < 2; c++)
			begin
				pins[c].tx                <= 1'b1;
				pins[c].user_output_two_n <= 1'b1;
				pins[c].rts_n             <= 1'b1;
				pins[c].dtr_n             <= 1'b1;
				pins[c].rx_ready_n        <= 1'b1;
				pins[c].tx_ready_n        <= 1'b0;
			end
		end
		else
		begin
			for (int c = 0; c < 2; c++)
			begin
				pins[c].tx                <= 1'b1;
				pins[c].user_output_two_n <= ~regs[c].modem_ctl[`DUR_MCR_OP2];
				pins[c].rts_n             <= ~regs[c].modem_ctl[`DUR_MCR_RTS];
				pins[c].dtr_n             <= ~regs[c].modem_ctl[`DUR_MCR_DTR];
				pins[c].rx_ready_n        <= 1'b1;
				pins[c].tx_ready_n        <= 1'b0;
			end
		end
	end

	always_comb
	begin
		next_rdata = '0;
		hit = 1'b1;
		unique case (ofs)
		`DUR_OFS_INT_EN:     next_rdata[7:0] = regs[ch].int_en;
		`DUR_OFS_INT_STAT:   next_rdata[7:0] = `DUR_RST_INT_STAT;
		`DUR_OFS_LINE_CTL:   next_rdata[7:0] = regs[ch].line_ctl;
		`DUR_OFS_MODEM_CTL:  next_rdata[7:0] = regs[ch].modem_ctl;
		`DUR_OFS_LINE_STAT:  next_rdata[7:0] = `DUR_RST_LINE_STAT;
		`DUR_OFS_MODEM_STAT: next_rdata[7:0] =
			modem_stat(live_modem[ch], modem_delta[ch]);
		`DUR_OFS_SCRATCH:    next_rdata[7:0] = regs[ch].scratch;
		`DUR_OFS_ENH_FEAT:   next_rdata[7:0] = regs[ch].enh_feat;
		`DUR_OFS_RESUME1:    next_rdata[7:0] = regs[ch].resume1;
		`DUR_OFS_RESUME2:    next_rdata[7:0] = regs[ch].resume2;
		`DUR_OFS_PAUSE1:     next_rdata[7:0] = regs[ch].pause1;
		`DUR_OFS_PAUSE2:     next_rdata[7:0] = regs[ch].pause2;
		`DUR_OFS_DIV_LO:     next_rdata[7:0] = div_lo[ch];
		`DUR_OFS_DIV_HI:     next_rdata[7:0] = div_hi[ch];
		`DUR_OFS_EVT_STAT:   next_rdata[`DUR_EVT_W-1:0] = evt_stat[ch];
		`DUR_OFS_EVT_EN:     next_rdata[`DUR_EVT_W-1:0] = evt_en[ch];
		`DUR_OFS_PWR_CTL:    next_rdata[0] = power_save;
		`DUR_OFS_FIFO_CTL, `DUR_OFS_EVT_CLR: next_rdata = '0;
		default:             hit = 1'b0;
		endcase
	end

	// Read data registered in setup so it is valid in the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (psel && !penable && !pwrite)
			prdata <= next_rdata;
	end

	property p_scratch_reset;
		@(posedge pclk) $rose(presetn) |-> regs[0].scratch == `DUR_RST_SCRATCH
			&& regs[1].scratch == `DUR_RST_SCRATCH;
	endproperty
	a_scratch_reset: assert property (p_scratch_reset)
		else $error("scratch not all ones after reset");

	property p_hold_until_write;
		@(posedge pclk) disable iff (!presetn)
		(phase == DUR_HOLD) |-> regs[0].enh_feat == 8'h00
			&& regs[1].pause2 == 8'h00 && regs[0].line_ctl == 8'h00;
	endproperty
	a_hold_until_write: assert property (p_hold_until_write)
		else $error("reset value changed before first write");

	property p_irq_tristate;
		@(posedge pclk) disable iff (!presetn)
		(phase == DUR_HOLD) |-> !irq_oe;
	endproperty
	a_irq_tristate: assert property (p_irq_tristate)
		else $error("interrupt driven before first write");

	property p_pins_idle;
		@(posedge pclk) $rose(presetn) |-> pins[0].tx && pins[1].rts_n
			&& pins[0].dtr_n && pins[1].rx_ready_n && !pins[0].tx_ready_n;
	endproperty
	a_pins_idle: assert property (p_pins_idle)
		else $error("pin reset level wrong");

	property p_isolate;
		@(posedge pclk) disable iff (!presetn)
		power_save |=> $stable(regs) && $stable(modem_in);
	endproperty
	a_isolate: assert property (p_isolate)
		else $error("input acted during power-save");

	property p_char_write;
		@(posedge pclk) disable iff (!presetn)
		wr_en && ofs == `DUR_OFS_RESUME1 |=> regs[$past(ch)].resume1
			== $past(pwdata[7:0]);
	endproperty
	a_char_write: assert property (p_char_write)
		else $error("resume character not stored");

	property p_status_reads;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && ofs == `DUR_OFS_LINE_STAT
			|=> prdata[7:0] == `DUR_RST_LINE_STAT;
	endproperty
	a_status_reads: assert property (p_status_reads)
		else $error("line status read wrong");

	property p_isr_reads;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && ofs == `DUR_OFS_INT_STAT
			|=> prdata[7:0] == `DUR_RST_INT_STAT;
	endproperty
	a_isr_reads: assert property (p_isr_reads)
		else $error("interrupt status read wrong");

	property p_no_false_delta;
		@(posedge pclk) disable iff (!presetn)
		!modem_primed |=> modem_delta == '0;
	endproperty
	a_no_false_delta: assert property (p_no_false_delta)
		else $error("modem change flagged at reset release");

	property p_sleep_scratch;
		@(posedge pclk) disable iff (!presetn)
		sleep_mode && !(wr_en && ofs == `DUR_OFS_SCRATCH)
			|=> $stable(regs[0].scratch) && $stable(regs[1].scratch);
	endproperty
	a_sleep_scratch: assert property (p_sleep_scratch)
		else $error("scratch changed during sleep");

	c_first_write: cover property (@(posedge pclk) $rose(phase == DUR_LIVE));
	c_irq: cover property (@(posedge pclk) irq && irq_oe);
	c_psave: cover property (@(posedge pclk) $rose(power_save));
endmodule

// *** verification/dur_modem_peer.sv ***
// Serial-side modem peer: drives the active-low modem inputs of both channels.
// Assumes the bench sets wanted pin levels; pins change just after pclk rises.
`timescale 1ns/10ps
module dur_modem_peer
(
	// Clock
	input  wire logic       pclk,
	// Wanted pin levels {cd,ri,dsr,cts}, channel 1 in the upper nibble
	input  wire logic [7:0] level,
	// Modem pins
	output logic      [1:0] cts_n,
	output logic      [1:0] dsr_n,
	output logic      [1:0] ri_n,
	output logic      [1:0] cd_n
);
	// Registered so the inputs stay synchronous, as the design expects
	always_ff @(posedge pclk)
	begin
		cts_n <= {level[4], level[0]};
		dsr_n <= {level[5], level[1]};
		ri_n  <= {level[6], level[2]};
		cd_n  <= {level[7], level[3]};
	end
endmodule

// *** verification/dur_top_bench.sv ***
// Self-checking bench: APB tasks, reset state, characters, events, power-save.
// Assumes the map header is on the include path and pready answers in time.
`timescale 1ns/10ps
`include "dur_map.svh"
module dur_top_bench
	import dur_pkg::*;
;
	logic                 pclk;
	logic                 presetn;
	logic                 psel;
	logic                 penable;
	logic                 pwrite;
	logic [11:0]          paddr;
	logic [31:0]          pwdata;
	logic [31:0]          prdata;
	logic                 pready;
	logic                 pslverr;
	logic [1:0]           cts_n;
	logic [1:0]           dsr_n;
	logic [1:0]           ri_n;
	logic [1:0]           cd_n;
	dur_chan_pins_t [1:0] pins;
	logic                 irq;
	logic                 irq_oe;
	logic                 sleep_mode;
	logic [7:0]           level;
	logic [31:0]          rdat;
	logic                 rerr;
	int                   mismatches;
	int                   checks;

	dur_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cts_n(cts_n),
		.dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n), .pins(pins), .irq(irq),
		.irq_oe(irq_oe), .sleep_mode(sleep_mode));

	dur_modem_peer peer (.pclk(pclk), .level(level), .cts_n(cts_n),
		.dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n));

	always #2.5 pclk = ~pclk;

	task finish_test;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Request held until pready is seen high at a rising edge, or for at most 50 edges
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 50);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'h1, a, {24'h00_0000, d});
	endtask

	task rd(input logic [11:0] a, input logic [7:0] exp);
		xfer(1'h0, a, 32'h0000_0000);
		chk(rdat, {24'h00_0000, exp});
	endtask

	task do_reset;
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
	endtask

	task chk_reset(input logic [11:0] b, input logic [7:0] modem_status);
		rd(b + `DUR_OFS_INT_EN, 8'h00);
		rd(b + `DUR_OFS_LINE_CTL, 8'h00);
		rd(b + `DUR_OFS_MODEM_CTL, 8'h00);
		rd(b + `DUR_OFS_INT_STAT, 8'h01);
		rd(b + `DUR_OFS_LINE_STAT, 8'h60);
		rd(b + `DUR_OFS_MODEM_STAT, modem_status);
		rd(b + `DUR_OFS_SCRATCH, 8'hFF);
		rd(b + `DUR_OFS_ENH_FEAT, 8'h00);
		for (int i = 0; i < 4; i++)
			rd(b + `DUR_OFS_RESUME1 + 12'(4 * i), 8'h00);
		chk({26'h000_0000, pins[b[8]]}, 32'h0000_003E);
	endtask

	initial
	begin
		repeat (2000) @(posedge pclk);
		mismatches++;
		finish_test;
	end

	initial
	begin
		pclk = 1'h0;
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		sleep_mode = 1'h0;
		level = 8'h7E;
		checks = 0;
		mismatches = 0;
		do_reset;
		repeat (4) @(posedge pclk);
		chk_reset(12'h000, 8'h10);
		chk_reset(12'h100, 8'h80);
		chk(irq_oe, 1'h0);
		for (int c = 0; c < 2; c++)
			for (int i = 0; i < 4; i++)
				wr(12'(256 * c + 36 + 4 * i), 8'(16 * c + i + 1));
		for (int c = 0; c < 2; c++)
			for (int i = 0; i < 4; i++)
				rd(12'(256 * c + 36 + 4 * i), 8'(16 * c + i + 1));
		chk(irq_oe, 1'h1);
		// Read-only status must ignore a write
		wr(`DUR_OFS_LINE_STAT, 8'hFF);
		rd(`DUR_OFS_LINE_STAT, 8'h60);
		wr(`DUR_OFS_SCRATCH, 8'hA5);
		rd(`DUR_OFS_SCRATCH, 8'hA5);
		xfer(1'h0, 12'h04C, 32'h0000_0000);
		chk(rerr, 1'h1);
		chk(rdat, 32'h0000_0000);
		wr(`DUR_OFS_EVT_EN, 8'h01);
		repeat (2) @(posedge pclk);
		chk(irq, 1'h1);
		wr(`DUR_OFS_EVT_EN, 8'h02);
		repeat (2) @(posedge pclk);
		chk(irq, 1'h0);
		level <= 8'h7F;
		repeat (6) @(posedge pclk);
		chk(irq, 1'h1);
		rd(`DUR_OFS_MODEM_STAT, 8'h01);
		rd(`DUR_OFS_MODEM_STAT, 8'h00);
		rd(`DUR_OFS_EVT_STAT, 8'h03);
		wr(`DUR_OFS_EVT_CLR, 8'h02);
		repeat (2) @(posedge pclk);
		chk(irq, 1'h0);
		wr(`DUR_OFS_PWR_CTL, 8'h01);
		repeat (2) @(posedge pclk);
		chk(irq_oe, 1'h0);
		wr(`DUR_OFS_SCRATCH, 8'h5A);
		level <= 8'h7D;
		repeat (6) @(posedge pclk);
		rd(`DUR_OFS_SCRATCH, 8'hA5);
		rd(`DUR_OFS_MODEM_STAT, 8'h00);
		wr(`DUR_OFS_PWR_CTL, 8'h00);
		sleep_mode <= 1'h1;
		repeat (4) @(posedge pclk);
		rd(`DUR_OFS_SCRATCH, 8'hA5);
		wr(12'h100 + `DUR_OFS_MODEM_CTL, 8'h0B);
		repeat (2) @(posedge pclk);
		chk({26'h000_0000, pins[1]}, 32'h0000_0022);
		do_reset;
		sleep_mode <= 1'h0;
		repeat (4) @(posedge pclk);
		chk_reset(12'h000, 8'h20);
		chk_reset(12'h100, 8'h80);
		finish_test;
	end
endmodule
